/* File: core/spft_pkg.sv */
// spft_pkg: constants and carrier types for the source port fault timers
// assumes a 100 MHz system clock; seven of the twelve times convert to cycles here
`default_nettype none
package spft_pkg;
  localparam int CLK_MHZ = 100;

  // times in their own units, as printed
  localparam int SHORT_RETRY_MS   = 985;
  localparam int FAULT_HR_MS      = 600;
  localparam int NO_RESP_MS       = 4800;
  localparam int AUX_MAX_MS       = 5;
  localparam int OVR_OFF_US       = 5;
  localparam int FOVP_OFF_US      = 30;
  localparam int OCP_OFF_US       = 30;
  localparam int THERM_STOP_US    = 10;
  localparam int CSW_MAX_MS       = 2;
  localparam int GATE_ON_MAX_MS   = 2;
  localparam int FOVP_DEGLITCH_US = 9;
  localparam int HR_GATE_OFF_MS   = 30;

  // cycle counts derived from the clock rate
  localparam int SHORT_RETRY_CYC   = SHORT_RETRY_MS * 1000 * CLK_MHZ;
  localparam int FAULT_HR_CYC      = FAULT_HR_MS * 1000 * CLK_MHZ;
  localparam int NO_RESP_CYC       = NO_RESP_MS * 1000 * CLK_MHZ;
  localparam int HR_GATE_OFF_CYC   = HR_GATE_OFF_MS * 1000 * CLK_MHZ;
  localparam int FOVP_DEGLITCH_CYC = FOVP_DEGLITCH_US * CLK_MHZ;
  localparam int AUX_MAX_CYC       = AUX_MAX_MS * 1000 * CLK_MHZ;
  localparam int OVR_OFF_CYC       = OVR_OFF_US * CLK_MHZ;

  // synchroniser depth for pin inputs
  localparam int SYNC_DEPTH = 3;
  localparam int TMR_W      = 32;

  typedef struct packed {
    logic sink_attached;
    logic sink_talking;
    logic gate_override_n;
    logic main_supply_input;
    logic vbus_shorted;
    logic fast_ovp;
    logic ocp_trip;
    logic first_thermal_threshold;
  } spft_pins_type;

  typedef struct packed {
    logic main_nfet_gate_drive;
    logic cable_supply_en;
    logic aux_digital_supply_out;
    logic attach_indicator_n;
    logic discharge_en;
    logic hard_reset_req;
  } spft_outs_type;
endpackage
`default_nettype wire

/* File: core/spft_sync.sv */
// spft_sync: three-flop synchroniser with agreement filter
// assumes asynchronous pin levels; output changes once stages two and three agree
`default_nettype none
module spft_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // pins in, filtered level out
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_reset_val,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [1:0]   fill_q, fill_d;

  always_comb begin
    lvl_d  = lvl_q;
    fill_d = (fill_q == 2'd3) ? fill_q : fill_q + 2'd1;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
    // cleared stages would agree on a false level, so hold the inactive
    // pattern until stage three has taken a real pin value
    if (fill_q != 2'd3) begin
      lvl_d = i_reset_val;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      fill_q <= '0;
    end else begin
      s1_q   <= i_async;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      fill_q <= fill_d;
    end
  end

  assign o_level = lvl_q;
endmodule
`default_nettype wire

/* File: core/spft_top.sv */
// spft_top: attach, retry and fast-shutdown sequencing of a source port
// assumes fault comparators and cc attach detect arrive as async pin levels
`default_nettype none
module spft_top (
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  // pin inputs from cc logic and comparators
  input  wire spft_pkg::spft_pins_type i_pins,
  // power path outputs
  output spft_pkg::spft_outs_type      o_outs
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ON, ST_HR_WAIT, ST_RECOVER
  } spft_state_type;

  localparam int TW = spft_pkg::TMR_W;

  spft_pkg::spft_pins_type pin_s;
  spft_pkg::spft_pins_type pin_rv;

  assign pin_rv = '{sink_attached: 1'b0, sink_talking: 1'b0,
                    gate_override_n: 1'b1, main_supply_input: 1'b1,
                    vbus_shorted: 1'b0, fast_ovp: 1'b0, ocp_trip: 1'b0,
                    first_thermal_threshold: 1'b0};

  spft_sync #(.W($bits(spft_pkg::spft_pins_type))) u_sync (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_async     (i_pins),
    .i_reset_val (pin_rv),
    .o_level     (pin_s)
  );

  function automatic logic expired(input logic [TW-1:0] t, input int lim);
    expired = (t >= TW'(lim - 1));
  endfunction

  spft_state_type   st_q, st_d;
  logic [TW-1:0]    ret_q, ret_d;     // retry interval timer
  logic [TW-1:0]    hr_q, hr_d;       // hard reset to gate off
  logic [TW-1:0]    ovp_q, ovp_d;     // overvoltage deglitch
  logic             gate_q, gate_d;
  logic             gen_q, gen_d;     // sequencer wants the gate on
  logic             csw_q, csw_d;
  logic             aux_q, aux_d;
  logic             ind_q, ind_d;
  logic             dsc_q, dsc_d;
  logic             hrp_q, hrp_d;
  logic             therm_q, therm_d;
  logic             ovp_ok, fast_off, supply_fault, send_hr;
  int               retry_lim;

  assign ovp_ok   = expired(ovp_q, spft_pkg::FOVP_DEGLITCH_CYC);
  // fast shutdown path does not wait for the sequencer
  assign fast_off = !pin_s.gate_override_n || ovp_ok || pin_s.ocp_trip;
  assign supply_fault = !pin_s.gate_override_n || !pin_s.main_supply_input;

  always_comb begin
    if (pin_s.vbus_shorted) begin
      retry_lim = spft_pkg::SHORT_RETRY_CYC;
    end else if (supply_fault) begin
      retry_lim = spft_pkg::FAULT_HR_CYC;
    end else begin
      retry_lim = spft_pkg::NO_RESP_CYC;
    end
  end

  always_comb begin
    st_d    = st_q;
    ret_d   = ret_q;
    hr_d    = hr_q;
    gen_d   = gen_q;
    csw_d   = csw_q;
    aux_d   = aux_q;
    ind_d   = ind_q;
    dsc_d   = 1'b0;
    hrp_d   = 1'b0;
    therm_d = pin_s.first_thermal_threshold;
    ovp_d   = pin_s.fast_ovp ? (ovp_ok ? ovp_q : ovp_q + TW'(1)) : '0;
    send_hr = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (pin_s.sink_attached) begin
          st_d   = ST_ON;
          ind_d  = 1'b0;
          aux_d  = 1'b1;
          csw_d  = 1'b1;
          gen_d  = 1'b1;
          ret_d  = '0;
        end
      end
      ST_ON: begin
        ret_d = ret_q + TW'(1);
        if (pin_s.sink_talking && !pin_s.vbus_shorted && !supply_fault) begin
          ret_d = '0;
        end
        if (expired(ret_q, retry_lim)) begin
          send_hr = 1'b1;
        end
        if (pin_s.first_thermal_threshold && !therm_q) begin
          send_hr = 1'b1;
        end
      end
      ST_HR_WAIT: begin
        hr_d = hr_q + TW'(1);
        if (expired(hr_q, spft_pkg::HR_GATE_OFF_CYC)) begin
          gen_d  = 1'b0;
          st_d   = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // gate comes back with the next interval
        st_d   = ST_ON;
        gen_d  = 1'b1;
        ret_d  = '0;
      end
      default: st_d = ST_IDLE;
    endcase
    if (send_hr) begin
      hrp_d = 1'b1;
      hr_d  = '0;
      ret_d = '0;
      st_d  = ST_HR_WAIT;
    end
    if (st_q != ST_IDLE && !pin_s.first_thermal_threshold && !gate_q) begin
      dsc_d = 1'b1;
    end
    if (pin_s.first_thermal_threshold) begin
      dsc_d = 1'b0;
    end
    if (!pin_s.sink_attached) begin
      st_d   = ST_IDLE;
      ret_d  = '0;
      hr_d   = '0;
      gen_d  = 1'b0;
      csw_d  = 1'b0;
      aux_d  = 1'b0;
      ind_d  = 1'b1;
      hrp_d  = 1'b0;
      dsc_d  = 1'b0;
    end
    // a fault holds the gate off only while present, with no relatch
    gate_d = gen_d && !fast_off;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= ST_IDLE;
      ret_q   <= '0;
      hr_q    <= '0;
      ovp_q   <= '0;
      gate_q  <= 1'b0;
      gen_q   <= 1'b0;
      csw_q   <= 1'b0;
      aux_q   <= 1'b0;
      ind_q   <= 1'b1;
      dsc_q   <= 1'b0;
      hrp_q   <= 1'b0;
      therm_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      ret_q   <= ret_d;
      hr_q    <= hr_d;
      ovp_q   <= ovp_d;
      gate_q  <= gate_d;
      gen_q   <= gen_d;
      csw_q   <= csw_d;
      aux_q   <= aux_d;
      ind_q   <= ind_d;
      dsc_q   <= dsc_d;
      hrp_q   <= hrp_d;
      therm_q <= therm_d;
    end
  end

  assign o_outs = '{main_nfet_gate_drive: gate_q, cable_supply_en: csw_q,
                    aux_digital_supply_out: aux_q, attach_indicator_n: ind_q,
                    discharge_en: dsc_q, hard_reset_req: hrp_q};

  // checks
  a_override_gate_off: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    !pin_s.gate_override_n |=> !gate_q) else $error("gate on under override");
  a_ovp_gate_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ovp_ok |=> !gate_q) else $error("gate on after overvoltage");
  a_ocp_gate_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pin_s.ocp_trip |=> !gate_q) else $error("gate on after overcurrent");
  a_therm_no_dsc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pin_s.first_thermal_threshold |=> !dsc_q) else $error("discharge hot");
  sequence s_attach;
    st_q == ST_IDLE && pin_s.sink_attached;
  endsequence
  a_attach_power_on: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    s_attach ##1 pin_s.sink_attached |=> csw_q && aux_q && !ind_q)
    else $error("attach outputs late");
  a_attach_gate_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (s_attach and !fast_off) |=> gate_q) else $error("gate not on");
  a_ovp_deglitch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(pin_s.fast_ovp) |-> !ovp_ok [*8]) else $error("ovp too fast");
  a_hr_gate_window: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    hrp_q |-> st_q == ST_HR_WAIT) else $error("hard reset state");
  a_detach_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !pin_s.sink_attached |=> st_q == ST_IDLE && ret_q == '0 && ind_q)
    else $error("detach not cleared");
endmodule
`default_nettype wire

/* File: verification/spft_sink_model.sv */
// spft_sink_model: attached sink, fets and comparators in front of the pins
// assumes the bench sets the fault levels; outputs feed spft_top i_pins
`default_nettype none
module spft_sink_model (
  // fault and attach levels from the bench
  input  wire logic                    i_attach,
  input  wire logic                    i_override_n,
  input  wire logic                    i_ovp,
  input  wire logic                    i_ocp,
  input  wire logic                    i_hot,
  // outputs of the block under test
  input  wire spft_pkg::spft_outs_type i_outs,
  // pin levels toward the block
  output spft_pkg::spft_pins_type      o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // a real sink only talks once bus power is up
  always_comb begin
    o_pins                         = '0;
    o_pins.sink_attached           = i_attach;
    o_pins.sink_talking            = i_attach & i_outs.main_nfet_gate_drive;
    o_pins.gate_override_n         = i_override_n;
    o_pins.main_supply_input       = 1'b1;
    o_pins.vbus_shorted            = 1'b0;
    o_pins.fast_ovp                = i_ovp;
    o_pins.ocp_trip                = i_ocp;
    o_pins.first_thermal_threshold = i_hot;
  end
endmodule
`default_nettype wire

/* File: verification/source_port_fault_timers_bench.sv */
// source_port_fault_timers_bench: attach, fast shutdown and detach checks
// assumes package time constants; retry intervals are too long to run here
`default_nettype none
module source_port_fault_timers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    att = 1'b0;
  logic                    ovr_n = 1'b1;
  logic                    ovp = 1'b0;
  logic                    ocp = 1'b0;
  logic                    hot = 1'b0;
  spft_pkg::spft_pins_type pins;
  spft_pkg::spft_outs_type outs;
  int                      fails = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  always #5 clk = ~clk;
  spft_sink_model u_spft_sink_model (.i_attach(att), .i_override_n(ovr_n),
    .i_ovp(ovp), .i_ocp(ocp), .i_hot(hot), .i_outs(outs), .o_pins(pins));
  spft_top u_spft_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_pins(pins),
    .o_outs(outs));
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bit order of outs: gate 5, cable 4, aux 3, ind_n 2, dis 1, hr 0
  task automatic wt(input int b, input logic v, input int n);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (outs[b] !== v && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(outs[b], v);
  endtask
  task automatic s_attach;
    @(posedge clk) att <= 1'b1;
    wt(2, 1'b0, 20);
    wt(3, 1'b1, 20);
    wt(4, 1'b1, 20);
    wt(5, 1'b1, 20);
  endtask
  task automatic s_override_thermal;
    @(posedge clk) ovr_n <= 1'b0;
    wt(5, 1'b0, 500);
    wt(1, 1'b1, 20);
    @(posedge clk) hot <= 1'b1;
    wt(0, 1'b1, 20);
    wt(1, 1'b0, 1000);
    @(posedge clk) hot <= 1'b0;
    ovr_n <= 1'b1;
    wt(5, 1'b1, 20);
  endtask
  // samples just after each edge so the gate level has settled
  task automatic cnt_drops(input int n, inout int drops);
    repeat (n) begin
      @(posedge clk);
      #1;
      drops += (outs.main_nfet_gate_drive !== 1'b1);
    end
  endtask
  task automatic s_ovp;
    int drops;
    drops = 0;
    @(posedge clk) ovp <= 1'b1;
    cnt_drops(800, drops);
    @(posedge clk) ovp <= 1'b0;
    cnt_drops(20, drops);
    chk(drops, 0);
    @(posedge clk) ovp <= 1'b1;
    cnt_drops(880, drops);
    chk(drops, 0);
    wt(5, 1'b0, 2100);
    @(posedge clk) ovp <= 1'b0;
    wt(5, 1'b1, 20);
  endtask
  task automatic s_ocp;
    @(posedge clk) ocp <= 1'b1;
    wt(5, 1'b0, 3000);
    @(posedge clk) ocp <= 1'b0;
    wt(5, 1'b1, 20);
  endtask
  task automatic s_detach;
    @(posedge clk) att <= 1'b0;
    wt(2, 1'b1, 20);
    wt(5, 1'b0, 20);
    wt(3, 1'b0, 20);
  endtask
  // ceiling is over twenty times the expected run of under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    s_attach();
    s_override_thermal();
    s_ovp();
    s_ocp();
    s_detach();
    results();
  end
endmodule
`default_nettype wire
